/* core/dvmo_defines.svh */
// Timing counts and field widths of the result output port
`ifndef DVMO_DEFINES_SVH
`define DVMO_DEFINES_SVH
`define DVMO_CLK_MHZ 50
`define DVMO_APERTURE_MS 3
`define DVMO_APERTURE_CYC (`DVMO_APERTURE_MS * 1000 * `DVMO_CLK_MHZ)
`define DVMO_FAST_RATE_HZ 30
`define DVMO_FAST_PERIOD_CYC (`DVMO_CLK_MHZ * 1000000 / `DVMO_FAST_RATE_HZ)
`define DVMO_SETTLE_BASE_MS 50
`define DVMO_SETTLE_BASE_CYC (`DVMO_SETTLE_BASE_MS * 1000 * `DVMO_CLK_MHZ)
`define DVMO_DIGITS 5
`define DVMO_FIFO_DEPTH 16
`define DVMO_WORD_W 36
`define DVMO_CNT_W 32
`endif

/* core/dvmo_fifo.sv */
// Result FIFO between measurement engine and output latches
`timescale 1ns/1ps
`default_nettype none
module dvmo_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } dvmo_fifo_s;
    dvmo_fifo_s q_r, q_nxt;
    logic push, pop;
    assign in_ready = (q_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (q_r.cnt != '0);
    assign out_data = q_r.mem[q_r.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_comb begin
        q_nxt = q_r;
        if (push) begin
            q_nxt.mem[q_r.wp] = in_data;
            q_nxt.wp = q_r.wp + AW'(1);
        end
        if (pop) begin
            q_nxt.rp = q_r.rp + AW'(1);
        end
        q_nxt.cnt = q_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule
`default_nettype wire

/* core/dvmo_pkg.sv */
// Types of the result output port
package dvmo_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETTLE, ST_SAMPLE, ST_GAP, ST_LOAD
    } dvmo_state_e;
endpackage

/* core/dvmo_port.sv */
// Result output port: trigger, settling sequencer, sample sync and gated outputs
`include "dvmo_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dvmo_port
    import dvmo_pkg::*;
#(
    parameter int APERTURE_CYC = `DVMO_APERTURE_CYC,
    parameter int FAST_PERIOD_CYC = `DVMO_FAST_PERIOD_CYC,
    parameter int SETTLE_BASE_CYC = `DVMO_SETTLE_BASE_CYC
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // Control inputs
    input wire logic EXT_TRIGGER,
    input wire logic TRIGGER_ENABLE,
    input wire logic FAST_SAMPLE_SELECT,
    // Measurement engine
    input wire logic [2:0] SETTLE_STEPS,
    input wire logic [2:0] AUTORANGE_STEPS,
    input wire logic [`DVMO_WORD_W-1:0] RESULT_DATA,
    input wire logic OVERLOAD_IN,
    output logic RESULT_STALL,
    // Gates
    input wire logic RANGE_CODE_GATE,
    input wire logic OVERRANGE_GATE,
    input wire logic [`DVMO_DIGITS-1:0] DIGIT_GATE,
    input wire logic PRIMARY_FUNCTION_GATE,
    input wire logic SECONDARY_FUNCTION_GATE,
    input wire logic STATUS_FLAG_GATE,
    // Result outputs
    output logic [2:0] RANGE_CODE,
    output logic OVERRANGE,
    output logic [4*`DVMO_DIGITS-1:0] DIGITS,
    output logic [3:0] PRIMARY_FUNCTION,
    output logic [3:0] SECONDARY_FUNCTION,
    // Flags
    output logic BUSY,
    output logic SAMPLE_SYNC_N,
    output logic OVERLOAD,
    output logic TRIGGERED
);
    // Word layout: range 3, overrange 1, digits 20, primary 4, secondary 4, spare 4
    typedef struct packed {
        dvmo_state_e st;
        logic trig_d;
        logic pending;
        logic [`DVMO_CNT_W-1:0] cnt;
        logic [`DVMO_CNT_W-1:0] rate_cnt;
        logic [3:0] steps_left;
        logic [`DVMO_WORD_W-1:0] word;
        logic ovl;
        logic busy;
        logic sync_n;
        logic trig_flag;
    } dvmo_port_s;
    dvmo_port_s q_r, q_nxt;
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [`DVMO_WORD_W-1:0] fifo_out_data;

    // Gate one output group; low gate holds it inactive
    function automatic logic [3:0] gated(input logic g, input logic [3:0] v);
        gated = g ? v : 4'h0;
    endfunction

    // ************************************************
    // Measurement sequencer
    // ************************************************
    logic edge_seen;
    assign edge_seen = EXT_TRIGGER ^ q_r.trig_d;
    assign RESULT_STALL = !fifo_in_ready;
    assign fifo_out_ready = (q_r.st == ST_LOAD);

    always_comb begin
        q_nxt = q_r;
        q_nxt.trig_d = EXT_TRIGGER;
        if (q_r.rate_cnt != '0) begin
            q_nxt.rate_cnt = q_r.rate_cnt - 1'b1;
        end
        if (edge_seen && TRIGGER_ENABLE) begin
            q_nxt.pending = 1'b1;
            q_nxt.trig_flag = 1'b1;
        end
        case (q_r.st)
            ST_IDLE: begin
                if (q_r.pending && q_r.rate_cnt == '0) begin
                    q_nxt.pending = 1'b0;
                    q_nxt.busy = 1'b1;
                    q_nxt.rate_cnt = `DVMO_CNT_W'(FAST_PERIOD_CYC - 1);
                    // settle steps by function and autorange
                    if (FAST_SAMPLE_SELECT) begin
                        q_nxt.steps_left = 4'h1;
                        q_nxt.st = ST_SAMPLE;
                        q_nxt.sync_n = 1'b0;
                        q_nxt.cnt = `DVMO_CNT_W'(APERTURE_CYC - 1);
                    end else begin
                        q_nxt.steps_left = 4'(SETTLE_STEPS) + 4'(AUTORANGE_STEPS) + 4'h1;
                        q_nxt.cnt = `DVMO_CNT_W'(SETTLE_BASE_CYC - 1);
                        q_nxt.st = ST_SETTLE;
                    end
                end
            end
            ST_SETTLE: begin
                if (q_r.cnt != '0) begin
                    q_nxt.cnt = q_r.cnt - 1'b1;
                end else begin
                    q_nxt.sync_n = 1'b0;
                    q_nxt.cnt = `DVMO_CNT_W'(APERTURE_CYC - 1);
                    q_nxt.st = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (q_r.cnt != '0) begin
                    q_nxt.cnt = q_r.cnt - 1'b1;
                end else begin
                    q_nxt.sync_n = 1'b1;
                    q_nxt.steps_left = q_r.steps_left - 4'h1;
                    if (q_r.steps_left == 4'h1) begin
                        q_nxt.st = ST_GAP;
                    end else begin
                        q_nxt.cnt = `DVMO_CNT_W'(SETTLE_BASE_CYC - 1);
                        q_nxt.st = ST_SETTLE;
                    end
                end
            end
            ST_GAP: begin
                // Capture into FIFO in the cycle after final aperture close, once the FIFO has room
                if (fifo_in_ready) begin
                    q_nxt.st = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (fifo_out_valid) begin
                    q_nxt.word = fifo_out_data;
                    q_nxt.ovl = OVERLOAD_IN;
                    q_nxt.busy = 1'b0;
                    q_nxt.st = ST_IDLE;
                end
            end
            default: q_nxt.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            q_r <= '{st: ST_IDLE, sync_n: 1'b1, default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    // ************************************************
    // Result buffering
    // ************************************************
    logic fifo_push;
    assign fifo_push = (q_r.st == ST_GAP) && fifo_in_ready;
    dvmo_fifo #(.WIDTH(`DVMO_WORD_W), .DEPTH(`DVMO_FIFO_DEPTH)) u_fifo (
        .clk(MCLK),
        .rst(RESET),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(RESULT_DATA),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ************************************************
    // Gated outputs
    // ************************************************
    // per-group gating
    assign RANGE_CODE = RANGE_CODE_GATE ? q_r.word[35:33] : 3'h0;
    assign OVERRANGE = OVERRANGE_GATE & q_r.word[32];
    genvar gi;
    generate
        for (gi = 0; gi < `DVMO_DIGITS; gi++) begin : g_dig
            assign DIGITS[4*gi +: 4] = gated(DIGIT_GATE[gi], q_r.word[12 + 4*gi +: 4]);
        end
    endgenerate
    assign PRIMARY_FUNCTION = gated(PRIMARY_FUNCTION_GATE, q_r.word[11:8]);
    assign SECONDARY_FUNCTION = gated(SECONDARY_FUNCTION_GATE, q_r.word[7:4]);
    assign BUSY = STATUS_FLAG_GATE & q_r.busy;
    assign SAMPLE_SYNC_N = STATUS_FLAG_GATE ? q_r.sync_n : 1'b0;
    assign OVERLOAD = STATUS_FLAG_GATE & q_r.ovl;
    assign TRIGGERED = STATUS_FLAG_GATE & q_r.trig_flag;
endmodule
`default_nettype wire

/* testbench/dvmo_acq_model.sv */
// Acquisition controller model driving the character gates
`timescale 1ns/1ps
`default_nettype none
module dvmo_acq_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic serial,
    input wire logic busy,
    output logic gate_range,
    output logic gate_over,
    output logic [4:0] gate_digit,
    output logic gate_prim,
    output logic gate_sec,
    output logic [7:0] scans
);
    typedef struct packed {logic [3:0] idx; logic busy_q; logic [7:0] scans;} dvmo_acq_s;
    dvmo_acq_s st_r, st_nxt;
    logic [8:0] oh;
    always_comb begin
        st_nxt = st_r;
        st_nxt.busy_q = busy;
        if (serial) begin
            st_nxt.idx = (st_r.idx == 4'h8) ? 4'h0 : st_r.idx + 4'h1;
        end
        if (st_r.busy_q && !busy) begin
            st_nxt.scans = st_r.scans + 8'h1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) st_r <= '0;
        else st_r <= st_nxt;
    end
    assign oh = serial ? (9'h1 << st_r.idx) : 9'h1ff;
    assign {gate_sec, gate_prim, gate_digit, gate_over, gate_range} = oh;
    assign scans = st_r.scans;
endmodule
`default_nettype wire

/* testbench/dvmo_port_bench.sv */
// Self-checking bench of the result output port
`include "dvmo_defines.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module dvmo_port_bench;
    typedef struct {logic fast; logic [2:0] st, ar; logic [35:0] d; logic ovl; int syncs;} dvmo_row_s;
    logic MCLK = 0, RESET = 1, EXT_TRIGGER = 0, TRIGGER_ENABLE = 1, FAST_SAMPLE_SELECT = 1;
    logic OVERLOAD_IN = 0, STATUS_FLAG_GATE = 1, serial = 0, last;
    logic [2:0] SETTLE_STEPS = 0, AUTORANGE_STEPS = 0, RANGE_CODE;
    logic [`DVMO_WORD_W-1:0] RESULT_DATA = 0;
    logic RESULT_STALL, RANGE_CODE_GATE, OVERRANGE_GATE, PRIMARY_FUNCTION_GATE, OVERRANGE;
    logic SECONDARY_FUNCTION_GATE, BUSY, SAMPLE_SYNC_N, OVERLOAD, TRIGGERED;
    logic [4:0] DIGIT_GATE;
    logic [19:0] DIGITS;
    logic [3:0] PRIMARY_FUNCTION, SECONDARY_FUNCTION;
    logic [7:0] scans;
    int n_mismatch = 0, comparisons = 0, syncs, k;
    dvmo_row_s rows[5] = '{'{1'b1, 3'h0, 3'h0, 36'h2_3456_7a9c, 1'b0, 1},
        '{1'b1, 3'h0, 3'h0, 36'hd_9876_5431, 1'b1, 1}, '{1'b0, 3'h0, 3'h0, 36'h4_0000_1000, 1'b0, 1},
        '{1'b0, 3'h1, 3'h2, 36'ha_5555_aaaa, 1'b0, 4}, '{1'b0, 3'h7, 3'h7, 36'h1_fedc_ba98, 1'b0, 15}};
    dvmo_port #(.APERTURE_CYC(5), .FAST_PERIOD_CYC(20), .SETTLE_BASE_CYC(8)) uut (.MCLK, .RESET,
        .EXT_TRIGGER, .TRIGGER_ENABLE, .FAST_SAMPLE_SELECT, .SETTLE_STEPS, .AUTORANGE_STEPS,
        .RESULT_DATA, .OVERLOAD_IN, .RESULT_STALL, .RANGE_CODE_GATE, .OVERRANGE_GATE, .DIGIT_GATE,
        .PRIMARY_FUNCTION_GATE, .SECONDARY_FUNCTION_GATE, .STATUS_FLAG_GATE, .RANGE_CODE,
        .OVERRANGE, .DIGITS, .PRIMARY_FUNCTION, .SECONDARY_FUNCTION, .BUSY, .SAMPLE_SYNC_N,
        .OVERLOAD, .TRIGGERED);
    dvmo_acq_model u_acq (.clk(MCLK), .rst(RESET), .serial(serial), .busy(BUSY),
        .gate_range(RANGE_CODE_GATE), .gate_over(OVERRANGE_GATE), .gate_digit(DIGIT_GATE),
        .gate_prim(PRIMARY_FUNCTION_GATE), .gate_sec(SECONDARY_FUNCTION_GATE), .scans(scans));
    initial forever #10 MCLK = ~MCLK;
    task end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Toggle trigger, count sync pulses until busy drops
    task measure(input dvmo_row_s r);
        @(negedge MCLK);
        {FAST_SAMPLE_SELECT, SETTLE_STEPS, AUTORANGE_STEPS} = {r.fast, r.st, r.ar};
        {RESULT_DATA, OVERLOAD_IN} = {r.d, r.ovl};
        EXT_TRIGGER = ~EXT_TRIGGER;
        for (k = 0; BUSY !== 1'b1 && k < 100; k++) @(negedge MCLK);
        syncs = 0;
        last = 1'b1;
        for (k = 0; BUSY === 1'b1 && k < 400; k++) begin
            if (SAMPLE_SYNC_N === 1'b0 && last) syncs++;
            last = SAMPLE_SYNC_N;
            @(negedge MCLK);
        end
    endtask
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge MCLK);
        `CHK("reset", 21'h0, {BUSY, DIGITS})
        @(negedge MCLK) RESET = 0;
        `CHK("stall", 1'b0, RESULT_STALL)
        $display("reset done");
        for (int i = 0; i < 5; i++) begin
            measure(rows[i]);
            `CHK("syncs", rows[i].syncs, syncs)
            `CHK("range", rows[i].d[35:32], {RANGE_CODE, OVERRANGE})
            `CHK("digits", rows[i].d[31:12], DIGITS)
            `CHK("funcs", rows[i].d[11:4], {PRIMARY_FUNCTION, SECONDARY_FUNCTION})
            `CHK("flags", {rows[i].ovl, 1'b1}, {OVERLOAD, TRIGGERED})
            $display("row %0d done", i);
        end
        // Disabled trigger must start nothing
        @(negedge MCLK) {TRIGGER_ENABLE, EXT_TRIGGER} = {1'b0, ~EXT_TRIGGER};
        repeat (40) @(negedge MCLK);
        TRIGGER_ENABLE = 1;
        repeat (4) @(negedge MCLK);
        `CHK("inhibit", 8'h5, {BUSY, 2'h0, scans[4:0]})
        $display("inhibit done");
        serial = 1;
        repeat (9) begin
            @(negedge MCLK);
            `CHK("char", DIGIT_GATE[0] ? rows[4].d[15:12] : 4'h0, DIGITS[3:0])
        end
        serial = 0;
        STATUS_FLAG_GATE = 0;
        @(negedge MCLK);
        `CHK("gated", 4'h0, {BUSY, SAMPLE_SYNC_N, OVERLOAD, TRIGGERED})
        STATUS_FLAG_GATE = 1;
        $display("gates done");
        // Two close edges merge into one measurement
        @(negedge MCLK) EXT_TRIGGER = ~EXT_TRIGGER;
        measure(rows[0]);
        repeat (40) @(negedge MCLK);
        `CHK("merge", 9'h6, {BUSY, scans})
        $display("merge done");
        end_of_test();
    end
endmodule
`default_nettype wire

/* testbench/dvmo_port_chk.sv */
// Checker for the result output port
`include "dvmo_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dvmo_port_chk
    import dvmo_pkg::*;
#(
    parameter int FAST_PERIOD_CYC = 20
) (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic FAST_SAMPLE_SELECT,
    input wire logic RANGE_CODE_GATE,
    input wire logic [`DVMO_DIGITS-1:0] DIGIT_GATE,
    input wire logic PRIMARY_FUNCTION_GATE,
    input wire logic STATUS_FLAG_GATE,
    input wire logic [2:0] RANGE_CODE,
    input wire logic [4*`DVMO_DIGITS-1:0] DIGITS,
    input wire logic [3:0] PRIMARY_FUNCTION,
    input wire logic BUSY,
    input wire logic SAMPLE_SYNC_N,
    input wire logic OVERLOAD,
    input wire logic TRIGGERED
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    logic busy_q_r;
    logic [31:0] gap_r;
    // Start spacing counter, no wrap within a short run
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            busy_q_r <= 1'b0;
            gap_r <= 32'h0000_ffff;
        end else begin
            busy_q_r <= BUSY;
            gap_r <= (BUSY && !busy_q_r) ? 32'h0 : gap_r + 32'h1;
        end
    end
    // Repeat counts hold only for an aperture of 5 cycles
    sequence aperture_s;
        !SAMPLE_SYNC_N [*5] ##1 SAMPLE_SYNC_N;
    endsequence
    sequence fast_meas_s;
        (BUSY && !SAMPLE_SYNC_N) [*5] ##1 (BUSY && SAMPLE_SYNC_N) [*2] ##1 !BUSY;
    endsequence
    a_range_gate_low: assert property (!RANGE_CODE_GATE |-> RANGE_CODE == 3'h0)
        else $error("range code driven with gate low");
    a_digit_gate_low: assert property (!DIGIT_GATE[0] |-> DIGITS[3:0] == 4'h0)
        else $error("digit driven with gate low");
    a_func_gate_low: assert property (!PRIMARY_FUNCTION_GATE |-> PRIMARY_FUNCTION == 4'h0)
        else $error("function driven with gate low");
    a_flag_gate_low: assert property (!STATUS_FLAG_GATE |-> {BUSY, SAMPLE_SYNC_N, OVERLOAD, TRIGGERED} == 4'h0)
        else $error("flags driven with gate low");
    a_sync_aperture_len: assert property ($fell(SAMPLE_SYNC_N) && STATUS_FLAG_GATE && $past(STATUS_FLAG_GATE) |-> aperture_s)
        else $error("aperture length wrong");
    a_fast_meas_walk: assert property ($rose(BUSY) && FAST_SAMPLE_SELECT |-> fast_meas_s)
        else $error("fast measurement walk wrong");
    a_start_rate_limit: assert property (BUSY && !busy_q_r |-> gap_r >= FAST_PERIOD_CYC - 1)
        else $error("starts closer than rate allows");
    a_idle_out_stable: assert property (!BUSY && !$past(BUSY) && $stable(DIGIT_GATE) |-> $stable(DIGITS))
        else $error("outputs moved while not busy");
endmodule
bind dvmo_port dvmo_port_chk #(.FAST_PERIOD_CYC(FAST_PERIOD_CYC)) u_chk (.MCLK, .RESET,
    .FAST_SAMPLE_SELECT, .RANGE_CODE_GATE, .DIGIT_GATE, .PRIMARY_FUNCTION_GATE,
    .STATUS_FLAG_GATE, .RANGE_CODE, .DIGITS, .PRIMARY_FUNCTION, .BUSY, .SAMPLE_SYNC_N,
    .OVERLOAD, .TRIGGERED);
`default_nettype wire
